// File: scl_pkg.sv
// constants, field layout and enumerations of the storm limiter
// assumes a single core clock and a plain register port
package scl_pkg;

    localparam int NUM_PORTS = 53;
    localparam int PORT_W = 6;
    localparam int NUM_CLS = 4;
    localparam int NUM_BKT = NUM_PORTS * NUM_CLS;
    localparam int BKT_W = 8;
    localparam int NUM_TICKS = 6;
    localparam int LVL_W = 24;
    localparam int LEN_W = 14;
    localparam int AW = 8;
    localparam int DW = 32;

    // global register byte addresses
    localparam logic [AW-1:0] ADDR_TICK_CFG = 8'h00;
    localparam logic [AW-1:0] ADDR_TICK_SEL = 8'h04;
    localparam logic [AW-1:0] ADDR_DROP_CNT = 8'h08;
    localparam logic [AW-1:0] ADDR_MC_HANDLE = 8'h0c;
    // class registers: bit 7 set, class in bits 6:5, word in bits 4:2
    localparam int CLS_SEL_BIT = 7;
    localparam int CLS_IDX_LSB = 5;
    localparam int CREG_LSB = 2;
    localparam logic [2:0] CREG_EN_LO = 3'h0;
    localparam logic [2:0] CREG_EN_HI = 3'h1;
    localparam logic [2:0] CREG_RATE = 3'h2;
    localparam logic [2:0] CREG_CAP = 3'h3;
    localparam logic [2:0] CREG_THR = 3'h4;
    localparam int EN_HI_W = NUM_PORTS - 32;

    // tick configuration fields
    localparam int TC_MASTER_LSB = 0;
    localparam int TC_MASTER_W = 16;
    localparam int TC_STAGE_LSB = 16;
    localparam int TC_STAGE_W = 8;
    localparam int TSEL_W = 2;

    // rate configuration fields
    localparam int RATE_UNIT_BIT = 0;
    localparam int RATE_TICK_LSB = 1;
    localparam int RATE_TICK_W = 3;
    localparam int RATE_TOK_LSB = 4;
    localparam int RATE_TOK_W = 16;
    localparam int RATE_GAP_LSB = 20;
    localparam int RATE_GAP_W = 8;
    localparam int MC_EXCL_BIT = 0;

    // reset values: 125 MHz / 125 = 1 MHz master tick, decades after it
    localparam logic [TC_MASTER_W-1:0] MASTER_RST = 16'h007d;
    localparam logic [TC_STAGE_W-1:0] STAGE_RST = 8'h0a;
    // 5% of 64-byte line rate at 1G: 74 packets per 1 kHz tick
    localparam logic [RATE_TOK_W-1:0] TOK_RST = 16'h004a;
    localparam logic [RATE_TICK_W-1:0] TICK_IDX_RST = 3'h3;
    localparam logic [RATE_GAP_W-1:0] GAP_RST = 8'h14;
    localparam logic UNIT_RST = 1'b1;
    localparam logic [LVL_W-1:0] CAP_RST = 24'h0005c8;
    localparam logic [LVL_W-1:0] THR_RST = 24'h0002e4;

    localparam int DA_GROUP_BIT = 40;
    localparam logic [47:0] DA_BCAST = 48'hffff_ffff_ffff;

    typedef enum logic [1:0] {
        SCL_CLS_BC = 2'b00,
        SCL_CLS_UMC = 2'b01,
        SCL_CLS_UUC = 2'b10,
        SCL_CLS_KMC = 2'b11
    } scl_cls_t;

    typedef enum logic [TSEL_W-1:0] {
        SCL_TSRC_CORE = 2'b00,
        SCL_TSRC_OFF = 2'b01,
        SCL_TSRC_DBG = 2'b10
    } scl_tsrc_t;

endpackage : scl_pkg

// File: scl_storm_limiter.sv
// tick chain and per-port, per-class storm limiting token buckets
// assumes one packet instance per cycle from the forwarding pipeline
`timescale 1ns/100ps
module scl_storm_limiter (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [scl_pkg::AW-1:0] reg_addr_i,
    input wire logic [scl_pkg::DW-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [scl_pkg::DW-1:0] reg_rdata_o,
    input wire logic dbg_write_data0_i,
    output logic [scl_pkg::NUM_TICKS-1:0] tick_o,
    input wire logic inst_valid_i,
    input wire logic [scl_pkg::PORT_W-1:0] inst_port_i,
    input wire logic [scl_pkg::LEN_W-1:0] inst_len_i,
    input wire logic [47:0] inst_da_i,
    input wire logic inst_l2_switched_i,
    input wire logic inst_da_known_i,
    input wire logic inst_mc_special_i,
    output logic inst_done_o,
    output logic inst_drop_o
);

    // register decode
    wire logic cls_acc = reg_addr_i[scl_pkg::CLS_SEL_BIT];
    wire logic [1:0] acc_cls = reg_addr_i[scl_pkg::CLS_IDX_LSB +: 2];
    wire logic [2:0] acc_reg = reg_addr_i[scl_pkg::CREG_LSB +: 3];
    wire logic wr_tick_cfg = reg_we_i && reg_addr_i == scl_pkg::ADDR_TICK_CFG;
    wire logic wr_tick_sel = reg_we_i && reg_addr_i == scl_pkg::ADDR_TICK_SEL;
    wire logic wr_drop_cnt = reg_we_i && reg_addr_i == scl_pkg::ADDR_DROP_CNT;
    wire logic wr_mc = reg_we_i && reg_addr_i == scl_pkg::ADDR_MC_HANDLE;
    wire logic wr_cls = reg_we_i && cls_acc && reg_addr_i[1:0] == 2'b00;

    logic [scl_pkg::TC_MASTER_W-1:0] master_fac_q;
    logic [scl_pkg::TC_STAGE_W-1:0] stage_fac_q;
    logic [scl_pkg::TSEL_W-1:0] tick_sel_q;
    logic mc_excl_q;
    logic [scl_pkg::DW-1:0] drop_cnt_q;
    logic [scl_pkg::NUM_PORTS-1:0] en_q [scl_pkg::NUM_CLS];
    logic unit_q [scl_pkg::NUM_CLS];
    logic [scl_pkg::RATE_TICK_W-1:0] tidx_q [scl_pkg::NUM_CLS];
    logic [scl_pkg::RATE_TOK_W-1:0] tok_q [scl_pkg::NUM_CLS];
    logic [scl_pkg::RATE_GAP_W-1:0] gap_q [scl_pkg::NUM_CLS];
    logic [scl_pkg::LVL_W-1:0] cap_q [scl_pkg::NUM_CLS];
    logic [scl_pkg::LVL_W-1:0] thr_q [scl_pkg::NUM_CLS];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            master_fac_q <= scl_pkg::MASTER_RST;
            stage_fac_q <= scl_pkg::STAGE_RST;
            tick_sel_q <= scl_pkg::SCL_TSRC_CORE;
            mc_excl_q <= 1'b0;
        end else begin
            if (wr_tick_cfg) begin
                master_fac_q <= reg_wdata_i[scl_pkg::TC_MASTER_LSB +: scl_pkg::TC_MASTER_W];
                stage_fac_q <= reg_wdata_i[scl_pkg::TC_STAGE_LSB +: scl_pkg::TC_STAGE_W];
            end
            if (wr_tick_sel) begin
                tick_sel_q <= reg_wdata_i[scl_pkg::TSEL_W-1:0];
            end
            if (wr_mc) begin
                mc_excl_q <= reg_wdata_i[scl_pkg::MC_EXCL_BIT];
            end
        end
    end

    // per-class configuration, each class its own set
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int c = 0; c < scl_pkg::NUM_CLS; c++) begin
                en_q[c] <= '0;
                unit_q[c] <= scl_pkg::UNIT_RST;
                tidx_q[c] <= scl_pkg::TICK_IDX_RST;
                tok_q[c] <= scl_pkg::TOK_RST;
                gap_q[c] <= scl_pkg::GAP_RST;
                cap_q[c] <= scl_pkg::CAP_RST;
                thr_q[c] <= scl_pkg::THR_RST;
            end
        end else if (wr_cls) begin
            unique case (acc_reg)
                scl_pkg::CREG_EN_LO: en_q[acc_cls][31:0] <= reg_wdata_i;
                scl_pkg::CREG_EN_HI: begin
                    en_q[acc_cls][scl_pkg::NUM_PORTS-1:32] <= reg_wdata_i[scl_pkg::EN_HI_W-1:0];
                end
                scl_pkg::CREG_RATE: begin
                    unit_q[acc_cls] <= reg_wdata_i[scl_pkg::RATE_UNIT_BIT];
                    tidx_q[acc_cls] <= reg_wdata_i[scl_pkg::RATE_TICK_LSB +: scl_pkg::RATE_TICK_W];
                    tok_q[acc_cls] <= reg_wdata_i[scl_pkg::RATE_TOK_LSB +: scl_pkg::RATE_TOK_W];
                    gap_q[acc_cls] <= reg_wdata_i[scl_pkg::RATE_GAP_LSB +: scl_pkg::RATE_GAP_W];
                end
                scl_pkg::CREG_CAP: cap_q[acc_cls] <= reg_wdata_i[scl_pkg::LVL_W-1:0];
                scl_pkg::CREG_THR: thr_q[acc_cls] <= reg_wdata_i[scl_pkg::LVL_W-1:0];
                default: ;
            endcase
        end
    end

    // debug source pin: two-stage synchroniser then edge detect
    logic dbg_s1_q;
    logic dbg_s2_q;
    logic dbg_s3_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            dbg_s3_q <= 1'b0;
        end else begin
            dbg_s1_q <= dbg_write_data0_i;
            dbg_s2_q <= dbg_s1_q;
            dbg_s3_q <= dbg_s2_q;
        end
    end
    wire logic dbg_rise = dbg_s2_q && !dbg_s3_q;

    // tick source select; the unused code counts as off
    wire logic src_en = (tick_sel_q == scl_pkg::SCL_TSRC_CORE) ||
        (tick_sel_q == scl_pkg::SCL_TSRC_DBG && dbg_rise);

    // a factor of zero behaves as one
    wire logic [scl_pkg::TC_MASTER_W-1:0] master_m1 =
        (master_fac_q == '0) ? '0 : master_fac_q - 16'h0001;
    wire logic [scl_pkg::TC_STAGE_W-1:0] stage_m1 =
        (stage_fac_q == '0) ? '0 : stage_fac_q - 8'h01;

    logic [scl_pkg::TC_MASTER_W-1:0] mst_cnt_q;
    logic [scl_pkg::TC_STAGE_W-1:0] stg_cnt_q [1:scl_pkg::NUM_TICKS-1];
    logic [scl_pkg::NUM_TICKS-1:0] tick_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mst_cnt_q <= '0;
            tick_q <= '0;
            for (int k = 1; k < scl_pkg::NUM_TICKS; k++) begin
                stg_cnt_q[k] <= '0;
            end
        end else if (wr_tick_cfg) begin
            // restart so the first new tick is a full new period
            mst_cnt_q <= '0;
            tick_q <= '0;
            for (int k = 1; k < scl_pkg::NUM_TICKS; k++) begin
                stg_cnt_q[k] <= '0;
            end
        end else begin
            tick_q[0] <= 1'b0;
            if (src_en) begin
                if (mst_cnt_q >= master_m1) begin
                    mst_cnt_q <= '0;
                    tick_q[0] <= 1'b1;
                end else begin
                    mst_cnt_q <= mst_cnt_q + 16'h0001;
                end
            end
            for (int k = 1; k < scl_pkg::NUM_TICKS; k++) begin
                tick_q[k] <= 1'b0;
                if (tick_q[k-1]) begin
                    if (stg_cnt_q[k] >= stage_m1) begin
                        stg_cnt_q[k] <= '0;
                        tick_q[k] <= 1'b1;
                    end else begin
                        stg_cnt_q[k] <= stg_cnt_q[k] + 8'h01;
                    end
                end
            end
        end
    end
    assign tick_o = tick_q;

    // per-class injection strobe from the selected tick
    logic [scl_pkg::NUM_CLS-1:0] inj;
    always_comb begin
        for (int c = 0; c < scl_pkg::NUM_CLS; c++) begin
            inj[c] = (tidx_q[c] < 3'(scl_pkg::NUM_TICKS)) && tick_q[tidx_q[c]];
        end
    end

    // classification of the arriving instance
    wire logic da_bc = inst_da_i == scl_pkg::DA_BCAST;
    wire logic da_grp = inst_da_i[scl_pkg::DA_GROUP_BIT];
    wire logic l2_unk = inst_l2_switched_i && !inst_da_known_i && !da_bc;
    wire logic is_umc = l2_unk && da_grp;
    wire logic is_uuc = l2_unk && !da_grp;
    wire logic is_kmc = inst_l2_switched_i && inst_da_known_i && da_grp && !da_bc &&
        !(mc_excl_q && inst_mc_special_i);
    wire logic cls_hit = da_bc || is_umc || is_uuc || is_kmc;
    wire logic [1:0] inst_cls = da_bc ? scl_pkg::SCL_CLS_BC :
        is_umc ? scl_pkg::SCL_CLS_UMC :
        is_uuc ? scl_pkg::SCL_CLS_UUC : scl_pkg::SCL_CLS_KMC;
    wire logic port_ok = inst_port_i < 6'(scl_pkg::NUM_PORTS);
    wire logic [scl_pkg::BKT_W-1:0] inst_idx = {inst_port_i, inst_cls};

    logic [scl_pkg::LVL_W-1:0] lvl_q [scl_pkg::NUM_BKT];
    logic [scl_pkg::LVL_W-1:0] lvl_d [scl_pkg::NUM_BKT];

    wire logic [scl_pkg::LVL_W-1:0] cur_lvl = port_ok ? lvl_q[inst_idx] : '0;
    wire logic bkt_en = port_ok && en_q[inst_cls][inst_port_i];
    wire logic judged = inst_valid_i && cls_hit && bkt_en;
    wire logic below = cur_lvl < thr_q[inst_cls];
    wire logic drop_now = judged && below;
    wire logic use_en = judged && !below;
    wire logic [scl_pkg::LVL_W-1:0] byte_cost =
        scl_pkg::LVL_W'(inst_len_i) + scl_pkg::LVL_W'(gap_q[inst_cls]);
    wire logic [scl_pkg::LVL_W-1:0] cost =
        unit_q[inst_cls] ? 24'h000001 : byte_cost;

    always_comb begin
        logic [scl_pkg::LVL_W-1:0] base;
        logic [scl_pkg::LVL_W:0] sum;
        base = '0;
        sum = '0;
        for (int b = 0; b < scl_pkg::NUM_BKT; b++) begin
            base = lvl_q[b];
            if (use_en && inst_idx == 8'(b)) begin
                base = (lvl_q[b] > cost) ? lvl_q[b] - cost : '0;
            end
            if (inj[b % scl_pkg::NUM_CLS]) begin
                sum = {1'b0, base} + 25'(tok_q[b % scl_pkg::NUM_CLS]);
                base = (sum > {1'b0, cap_q[b % scl_pkg::NUM_CLS]}) ?
                    cap_q[b % scl_pkg::NUM_CLS] : sum[scl_pkg::LVL_W-1:0];
            end
            lvl_d[b] = base;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int b = 0; b < scl_pkg::NUM_BKT; b++) begin
                lvl_q[b] <= scl_pkg::CAP_RST;
            end
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // decision and drop counter; a drop in the cycle of a clear leaves the count at one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inst_done_o <= 1'b0;
            inst_drop_o <= 1'b0;
            drop_cnt_q <= '0;
        end else begin
            inst_done_o <= inst_valid_i;
            inst_drop_o <= drop_now;
            if (drop_now) begin
                drop_cnt_q <= (wr_drop_cnt ? '0 : drop_cnt_q) + 32'h0000_0001;
            end else if (wr_drop_cnt) begin
                drop_cnt_q <= '0;
            end
        end
    end

    // read mux; unmapped reads return zero
    logic [scl_pkg::DW-1:0] cls_rd;
    always_comb begin
        cls_rd = '0;
        unique case (acc_reg)
            scl_pkg::CREG_EN_LO: cls_rd = en_q[acc_cls][31:0];
            scl_pkg::CREG_EN_HI: cls_rd = 32'(en_q[acc_cls][scl_pkg::NUM_PORTS-1:32]);
            scl_pkg::CREG_RATE: begin
                cls_rd[scl_pkg::RATE_UNIT_BIT] = unit_q[acc_cls];
                cls_rd[scl_pkg::RATE_TICK_LSB +: scl_pkg::RATE_TICK_W] = tidx_q[acc_cls];
                cls_rd[scl_pkg::RATE_TOK_LSB +: scl_pkg::RATE_TOK_W] = tok_q[acc_cls];
                cls_rd[scl_pkg::RATE_GAP_LSB +: scl_pkg::RATE_GAP_W] = gap_q[acc_cls];
            end
            scl_pkg::CREG_CAP: cls_rd = 32'(cap_q[acc_cls]);
            scl_pkg::CREG_THR: cls_rd = 32'(thr_q[acc_cls]);
            default: cls_rd = '0;
        endcase
    end
    wire logic [scl_pkg::DW-1:0] tick_cfg_rd =
        {8'h00, stage_fac_q, master_fac_q};
    wire logic [scl_pkg::DW-1:0] rd_mux =
        (cls_acc && reg_addr_i[1:0] == 2'b00) ? cls_rd :
        (reg_addr_i == scl_pkg::ADDR_TICK_CFG) ? tick_cfg_rd :
        (reg_addr_i == scl_pkg::ADDR_TICK_SEL) ? 32'(tick_sel_q) :
        (reg_addr_i == scl_pkg::ADDR_DROP_CNT) ? drop_cnt_q :
        (reg_addr_i == scl_pkg::ADDR_MC_HANDLE) ? 32'(mc_excl_q) : '0;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_re_i ? rd_mux : '0;
        end
    end

    AST_MASTER_TICK_SPACED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tick_q[0] && master_m1 != '0 && !wr_tick_cfg |=> !tick_q[0])
        else $error("master tick pulses back to back with factor above one");

    AST_STAGE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tick_q[1] |-> $past(tick_q[0]))
        else $error("stage tick without preceding tick");

    AST_CFG_RESTART: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_tick_cfg |=> mst_cnt_q == '0 && tick_q == '0)
        else $error("tick dividers not restarted on config write");

    AST_SRC_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tick_sel_q == scl_pkg::SCL_TSRC_OFF && !wr_tick_cfg && !wr_tick_sel
        |=> $stable(mst_cnt_q) && !tick_q[0])
        else $error("master divider moved while source off");

    AST_BC_CLASS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && inst_da_i == scl_pkg::DA_BCAST |-> inst_cls == scl_pkg::SCL_CLS_BC)
        else $error("all-ones destination not broadcast");

    AST_ACCEPT_ABOVE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && !below |=> !inst_drop_o)
        else $error("drop while level at or above threshold");

    AST_DROP_BELOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        judged && cur_lvl < thr_q[inst_cls] |=> inst_drop_o && inst_done_o)
        else $error("no drop while enabled level below threshold");

    AST_DISABLED_PASS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && !bkt_en |=> !inst_drop_o)
        else $error("disabled bucket dropped traffic");

    AST_DROP_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_drop_o && !$past(wr_drop_cnt) |-> drop_cnt_q == $past(drop_cnt_q) + 32'h0000_0001)
        else $error("drop counter not bumped by one");

    AST_CAP_SAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && port_ok && inj[inst_cls] && !wr_cls
        |=> lvl_q[$past(inst_idx)] <= cap_q[$past(inst_cls)])
        else $error("bucket level above capacity after injection");

    AST_PKT_COST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        use_en && unit_q[inst_cls] && !inj[inst_cls] && cur_lvl != '0
        |=> lvl_q[$past(inst_idx)] == $past(cur_lvl) - 24'h000001)
        else $error("packet mode did not lower level by one");

    AST_DROP_NO_DRAIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        drop_now && !inj[inst_cls]
        |=> lvl_q[$past(inst_idx)] == $past(cur_lvl))
        else $error("dropped instance changed bucket level");

    AST_DISABLED_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && port_ok && !bkt_en && !inj[inst_cls]
        |=> lvl_q[$past(inst_idx)] == $past(cur_lvl))
        else $error("disabled bucket level drained");

    AST_KMC_EXCL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i && mc_excl_q && inst_mc_special_i && inst_da_known_i && !da_bc
        |=> !inst_drop_o)
        else $error("excluded known multicast was dropped");

    AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        inst_valid_i |=> inst_done_o)
        else $error("instance not answered in next cycle");

    AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !reg_re_i |=> reg_rdata_o == '0)
        else $error("read data not zero outside read answer");

endmodule : scl_storm_limiter

// File: scl_fwd_model.sv
// forwarding pipeline model handing one packet instance to the limiter per call
// assumes the limiter answers in the cycle after each instance
`timescale 1ns/100ps
module scl_fwd_model (
    input wire logic clk_i,
    input wire logic inst_done_i,
    input wire logic inst_drop_i,
    output logic inst_valid_o,
    output logic [scl_pkg::PORT_W-1:0] inst_port_o,
    output logic [scl_pkg::LEN_W-1:0] inst_len_o,
    output logic [47:0] inst_da_o,
    output logic inst_l2_o,
    output logic inst_known_o,
    output logic inst_special_o
);
    initial begin
        inst_valid_o = 1'b0;
        inst_port_o = '0;
        inst_len_o = '0;
        inst_da_o = '0;
        inst_l2_o = 1'b0;
        inst_known_o = 1'b0;
        inst_special_o = 1'b0;
    end

    task automatic send(input logic [scl_pkg::PORT_W-1:0] port,
        input logic [scl_pkg::LEN_W-1:0] len, input logic [47:0] da, input logic known,
        input logic special, output logic done, output logic drop);
        @(posedge clk_i);
        inst_valid_o <= 1'b1;
        inst_port_o <= port;
        inst_len_o <= len;
        inst_da_o <= da;
        inst_l2_o <= 1'b1;
        inst_known_o <= known;
        inst_special_o <= special;
        @(posedge clk_i);
        // valid and l2 drop low once released; the other fields invert
        inst_valid_o <= 1'b0;
        inst_port_o <= ~port;
        inst_len_o <= ~len;
        inst_da_o <= ~da;
        inst_l2_o <= 1'b0;
        inst_known_o <= ~known;
        inst_special_o <= ~special;
        #1;
        done = inst_done_i;
        drop = inst_drop_i;
    endtask : send
endmodule : scl_fwd_model

// File: scl_storm_limiter_test.sv
// bench for the storm limiter: register reset values, tick chain, buckets
// assumes the forwarding model drives the instance stream on the same clock
`timescale 1ns/100ps
module scl_storm_limiter_test;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;
    logic clk, rst_b, we, re, dbg, v, l2, kn, sp, done, drop;
    logic spec = 1'b0;
    logic [7:0] addr;
    logic [31:0] wd, rdata;
    logic [5:0] tick, port;
    logic [13:0] len;
    logic [47:0] da;
    logic [31:0] tcnt [3] = '{32'h0, 32'h0, 32'h0};
    int miscompares = 0;
    int samples_checked = 0;

    scl_storm_limiter scl_storm_limiter_inst (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .dbg_write_data0_i(dbg), .tick_o(tick), .inst_valid_i(v), .inst_port_i(port),
        .inst_len_i(len), .inst_da_i(da), .inst_l2_switched_i(l2), .inst_da_known_i(kn),
        .inst_mc_special_i(sp), .inst_done_o(done), .inst_drop_o(drop));
    scl_fwd_model scl_fwd_model_inst (.clk_i(clk), .inst_done_i(done), .inst_drop_i(drop),
        .inst_valid_o(v), .inst_port_o(port), .inst_len_o(len), .inst_da_o(da),
        .inst_l2_o(l2), .inst_known_o(kn), .inst_special_o(sp));

    always @(posedge clk) begin
        for (int k = 0; k < 3; k++) begin
            if (tick[k] === 1'b1) tcnt[k] <= tcnt[k] + 32'h1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic pkt(input logic [5:0] p, input logic [13:0] n, input logic [47:0] a,
        input logic k, input logic e);
        logic dn, dr;
        scl_fwd_model_inst.send(p, n, a, k, spec, dn, dr);
        chk("inst_done", 32'h1, {31'h0, dn});
        chk("inst_drop", {31'h0, e}, {31'h0, dr});
    endtask : pkt

    task automatic t_reset();
        logic [7:0] ad [7] = '{8'h00, 8'h04, 8'h88, 8'h8c, 8'h90, 8'h80, 8'h10};
        logic [31:0] ex [7] = '{32'h000a_007d, 32'h0, 32'h0140_04a7, 32'h0000_05c8,
            32'h0000_02e4, 32'h0, 32'h0};
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            rd(ad[i], d);
            chk("reset_reg", ex[i], d);
        end
    endtask : t_reset

    task automatic t_ticks();
        logic [31:0] b [3];
        wr(8'h00, 32'h0002_0002);
        repeat (16) @(posedge clk);
        b = tcnt;
        repeat (40) @(posedge clk);
        chk("tick0", 32'd20, tcnt[0] - b[0]);
        chk("tick1", 32'd10, tcnt[1] - b[1]);
        chk("tick2", 32'd5, tcnt[2] - b[2]);
        wr(8'h04, 32'h1);
        repeat (4) @(posedge clk);
        b = tcnt;
        repeat (40) @(posedge clk);
        chk("tick_off", 32'd0, tcnt[0] - b[0]);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h0002_0002);
        repeat (4) @(posedge clk);
        b = tcnt;
        repeat (16) begin
            repeat (2) @(posedge clk);
            dbg <= ~dbg;
        end
        repeat (8) @(posedge clk);
        chk("tick_dbg", 32'd4, tcnt[0] - b[0]);
        wr(8'h04, 32'h0);
    endtask : t_ticks

    task automatic t_drop();
        logic [31:0] d;
        wr(8'h88, 32'h0000_000f);
        wr(8'h90, 32'h0000_05c6);
        wr(8'h80, 32'h0000_0028);
        repeat (3) pkt(6'd3, 14'd64, BC, 1'b0, 1'b0);
        pkt(6'd3, 14'd64, BC, 1'b0, 1'b1);
        pkt(6'd3, 14'd64, 48'h0000_0000_0001, 1'b1, 1'b0);
        pkt(6'd5, 14'd64, BC, 1'b0, 1'b0);
        pkt(6'd4, 14'd64, BC, 1'b0, 1'b0);
        rd(8'h08, d);
        chk("drop_cnt", 32'd1, d);
        wr(8'h08, 32'h0);
        rd(8'h08, d);
        chk("drop_cnt", 32'd0, d);
    endtask : t_drop

    task automatic t_refill();
        wr(8'h88, 32'h0000_0011);
        repeat (100) @(posedge clk);
        wr(8'h88, 32'h0000_000f);
        repeat (3) pkt(6'd3, 14'd64, BC, 1'b0, 1'b0);
        pkt(6'd3, 14'd64, BC, 1'b0, 1'b1);
    endtask : t_refill

    task automatic t_bytes();
        logic [31:0] d;
        logic [47:0] a;
        logic [7:0] b;
        for (int c = 1; c < 4; c++) begin
            a = (c == 2) ? 48'h0200_0000_0001 : 48'h0100_0000_0001;
            b = 8'h80 + 8'(c * 32);
            wr(b + 8'h08, 32'h0140_000e);
            wr(b + 8'h10, 32'h0000_0579);
            wr(b, 32'h0000_0008);
            pkt(6'd3, 14'd60, a, c == 3, 1'b0);
            pkt(6'd3, 14'd60, a, c == 3, 1'b1);
        end
        rd(8'h08, d);
        chk("drop_cnt", 32'd4, d);
        // flagged known multicast excluded once the handling bit is set
        wr(8'h0c, 32'h1);
        spec = 1'b1;
        pkt(6'd3, 14'd60, 48'h0100_0000_0001, 1'b1, 1'b0);
        spec = 1'b0;
        pkt(6'd3, 14'd60, 48'h0100_0000_0001, 1'b1, 1'b1);
        rd(8'h08, d);
        chk("drop_cnt", 32'd5, d);
    endtask : t_bytes

    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = '0;
        wd = '0;
        dbg = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_ticks();
        t_drop();
        t_refill();
        t_bytes();
        report_and_stop();
    end

    // whole run is under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule : scl_storm_limiter_test
